//--- wdsr_top.sv
/*
 * Watchdog counter with optional prescaler, sleep entry and wake-up,
 * reset-cause flags, device reset timer, identification words and the
 * serial programming entry and shifter.
 * Assumes the core gives one-cycle strobes on the system clock, that all
 * pins are asynchronous and that program memory answers combinationally.
 */
`include "wdsr_regs.svh"

// Function
// - Watchdog counts its own free-running oscillator.
// - Watchdog timeout resets device, awake or asleep.
// - Timeout reset clears the timeout flag.
// - Fuse at zero disables watchdog permanently.
// - Nominal timeout 18 ms without prescaler.
// - Software assigns prescaler up to 1:128.
// - Kick clears counter and assigned prescaler.
// - Sleep clears counter and assigned prescaler.
// - Reset cause encoded in four flags.
// - Flags hold until reset or sleep; other pulses leave them.
// - Sleep: clear watchdog, set timeout flag, clear powerdown flag, oscillator off.
// - Pins keep their state during sleep.
// - Watchdog reset never drives reset pin.
// - Four wake sources reset the device.
// - Pin and comparator changes set wake flags.
// - Compare pins with last read value.
// - Watchdog cleared on every wake.
// - Readout limited by code protection.
// - Four ID words, programming mode only.
// - Low pins plus high voltage enter programming.
// - Six-bit command then sixteen data bits.
// - Reset timer holds core after reset.
module wdsr_top #(
  parameter logic [17:0] P_DEVRST_POR_CYC = 18'(`WDSR_DEVRST_POR_CYC),
  parameter logic [13:0] P_WD_TICKS = 14'(`WDSR_WD_TICKS)
) (
  input wire logic I_CLK_SYS, // System clock, 10 MHz.
  input wire logic I_RST, // Power-on reset, synchronous, high.
  input wire logic [1:0] I_ADDR, // Register address.
  input wire logic [7:0] I_WDATA, // Register write data.
  input wire logic I_WE, // Write strobe.
  input wire logic I_RE, // Read strobe.
  output logic [7:0] O_RDATA, // Read data, one cycle after the strobe.
  input wire logic I_KICK, // Core executed the kick instruction.
  input wire logic I_SLEEP, // Core executed the sleep instruction.
  input wire logic I_PORT_ACCESS, // Core did a file or bit operation on the port.
  input wire logic I_CFG_WD_FUSE, // Watchdog enable fuse, 1 enables.
  input wire logic I_CFG_RSTPIN_EN, // Reset function of pin 3 enabled.
  input wire logic I_CFG_CP_N, // Code protection, low when programmed.
  input wire logic I_WDT_OSC, // Watchdog oscillator, asynchronous.
  input wire logic I_CMP_OUT, // Comparator output, asynchronous.
  input wire logic I_PORT_PIN0, // Port pin 0 level.
  input wire logic I_PORT_PIN1, // Port pin 1 level.
  input wire logic I_PORT_PIN3, // Port pin 3 level, also reset pin.
  input wire logic I_PIN3_HV, // Pin 3 at the programming high level.
  input wire logic [11:0] I_PMEM_RDATA, // Program memory word at O_PMEM_ADDR.
  output logic O_CORE_RST, // Core held in reset.
  output logic O_CORE_CLK_EN, // Main oscillator driver on.
  output logic O_IO_HOLD, // Port drivers frozen.
  output logic O_RSTPIN_OE_N, // Reset pin output enable, low drives.
  output logic O_PIN0_OUT, // Programming data out.
  output logic O_PIN0_OE_N, // Programming data enable, low drives.
  output logic O_PROG_MODE, // Programming mode active.
  output logic [9:0] O_PMEM_ADDR, // Programming address.
  output logic O_PMEM_RD_OK // Address may be read out.
);

  // ****************************************************************
  // Decoding functions
  // ****************************************************************

  // Prescaler carry for ratio 1:2^ratio; ratio 0 passes every tick.
  function automatic logic presc_done(input logic [6:0] cnt, input logic [2:0] ratio);
    logic [7:0] m;
    m = (8'h01 << ratio) - 8'h01;
    return (cnt & m[6:0]) == m[6:0];
  endfunction : presc_done

  function automatic logic is_id(input logic [9:0] a);
    return (a[9:2] == 8'(`WDSR_ID_BASE >> 2));
  endfunction : is_id

  function automatic logic read_allowed(input logic [9:0] a, input logic cp_n);
    return cp_n || (a < `WDSR_OPEN_LIMIT) || (a == `WDSR_LAST_ADDR) || is_id(a);
  endfunction : read_allowed

  // ****************************************************************
  // State
  // ****************************************************************
  wdsr_pkg::wdsr_state_t q_r;
  wdsr_pkg::wdsr_state_t q_nxt;
  logic osc_tick;
  logic pre_tick;
  logic wd_on;
  logic wd_expire;
  logic [2:0] pins_now;
  logic pin_diff;
  logic cmp_diff;
  logic rstpin_low;
  logic hv_rise;
  logic pg_clk_rise;
  logic sleep_go;
  logic kick_go;
  logic [5:0] cmd_v;
  logic [15:0] word_v;

  // Next-state logic; priorities are programming entry, reset pin,
  // watchdog, then wake sources and instructions.
  always_comb begin
    q_nxt = q_r;
    osc_tick = 1'b0;
    pre_tick = 1'b0;
    wd_on = 1'b0;
    wd_expire = 1'b0;
    pins_now = 3'h0;
    pin_diff = 1'b0;
    cmp_diff = 1'b0;
    rstpin_low = 1'b0;
    hv_rise = 1'b0;
    pg_clk_rise = 1'b0;
    sleep_go = 1'b0;
    kick_go = 1'b0;
    cmd_v = 6'h00;
    word_v = 16'h0000;

    // Three-stage synchronisers; a level counts once stages two and three agree.
    q_nxt.s1 = {I_PIN3_HV, I_PORT_PIN3, I_PORT_PIN1, I_PORT_PIN0, I_CMP_OUT, I_WDT_OSC};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int i = 0; i < `WDSR_SY_W; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.stab[i] = q_r.s2[i];
      end
    end
    osc_tick = q_nxt.stab[`WDSR_SY_OSC] & ~q_r.stab[`WDSR_SY_OSC];
    hv_rise = q_nxt.stab[`WDSR_SY_HV] & ~q_r.stab[`WDSR_SY_HV];
    pg_clk_rise = q_nxt.stab[`WDSR_SY_PIN1] & ~q_r.stab[`WDSR_SY_PIN1];
    pins_now = {q_r.stab[`WDSR_SY_PIN3], q_r.stab[`WDSR_SY_PIN1], q_r.stab[`WDSR_SY_PIN0]};
    pin_diff = (pins_now != q_r.port_latch);
    cmp_diff = (q_r.stab[`WDSR_SY_CMP] != q_r.cmp_latch);
    rstpin_low = I_CFG_RSTPIN_EN & ~q_r.stab[`WDSR_SY_PIN3];

    // Watchdog counter, stopped for good when the fuse is zero.
    wd_on = I_CFG_WD_FUSE && (q_r.mode == wdsr_pkg::ST_RUN || q_r.mode == wdsr_pkg::ST_SLEEP);
    pre_tick = osc_tick && (!q_r.option[`WDSR_OPT_PRE_ASSIGN] ||
               presc_done(q_r.presc, q_r.option[`WDSR_OPT_RATIO_HI:`WDSR_OPT_RATIO_LO]));
    wd_expire = wd_on && pre_tick && (q_r.wd_cnt == P_WD_TICKS - 14'h0001);
    if (osc_tick && q_r.option[`WDSR_OPT_PRE_ASSIGN]) begin
      q_nxt.presc = q_r.presc + 7'h01;
    end
    if (wd_on && pre_tick) begin
      q_nxt.wd_cnt = q_r.wd_cnt + 14'h0001;
    end

    // Register bus; reads answer for one cycle only, unmapped reads give zero.
    q_nxt.rdata = 8'h00;
    if (I_WE && I_ADDR == `WDSR_ADDR_OPTION) begin
      q_nxt.option = I_WDATA;
    end
    if (I_WE && I_ADDR == `WDSR_ADDR_WAKECTL) begin
      q_nxt.cmp_en = I_WDATA[`WDSR_WAKECTL_CMP_EN];
    end
    if (I_RE && I_ADDR == `WDSR_ADDR_STATUS) begin
      q_nxt.rdata[`WDSR_STAT_PIN_WAKE] = q_r.flags[`WDSR_F_PIN];
      q_nxt.rdata[`WDSR_STAT_CMP_WAKE] = q_r.flags[`WDSR_F_CMP];
      q_nxt.rdata[`WDSR_STAT_TIMEOUT] = q_r.flags[`WDSR_F_TIMEOUT];
      q_nxt.rdata[`WDSR_STAT_PDOWN] = q_r.flags[`WDSR_F_PDOWN];
    end
    if (I_RE && I_ADDR == `WDSR_ADDR_WAKECTL) begin
      q_nxt.rdata[`WDSR_WAKECTL_CMP_EN] = q_r.cmp_en;
    end

    case (q_r.mode)
      // Device reset timer; a held reset pin keeps it from counting.
      wdsr_pkg::ST_HOLD: begin
        q_nxt.core_rst = 1'b1;
        q_nxt.wd_cnt = 14'h0000;
        q_nxt.presc = 7'h00;
        if (!rstpin_low) begin
          if (q_r.devrst == 18'h00000) begin
            q_nxt.mode = wdsr_pkg::ST_RUN;
            q_nxt.core_rst = 1'b0;
          end else begin
            q_nxt.devrst = q_r.devrst - 18'h00001;
          end
        end
      end
      wdsr_pkg::ST_RUN: begin
        if (I_PORT_ACCESS) begin
          q_nxt.port_latch = pins_now;
        end
        if (rstpin_low) begin
          q_nxt.flags[`WDSR_F_CMP] = 1'b0;
          q_nxt.flags[`WDSR_F_PIN] = 1'b0;
        end else if (wd_expire) begin
          q_nxt.flags[`WDSR_F_CMP] = 1'b0;
          q_nxt.flags[`WDSR_F_PIN] = 1'b0;
          q_nxt.flags[`WDSR_F_TIMEOUT] = 1'b0;
        end else if (I_SLEEP) begin
          sleep_go = 1'b1;
          q_nxt.mode = wdsr_pkg::ST_SLEEP;
          q_nxt.wd_cnt = 14'h0000;
          q_nxt.flags[`WDSR_F_TIMEOUT] = 1'b1;
          q_nxt.flags[`WDSR_F_PDOWN] = 1'b0;
          q_nxt.clk_en = 1'b0;
          q_nxt.io_hold = 1'b1;
          q_nxt.cmp_latch = q_r.stab[`WDSR_SY_CMP];
          if (q_r.option[`WDSR_OPT_PRE_ASSIGN]) begin
            q_nxt.presc = 7'h00;
          end
        end else if (I_KICK) begin
          kick_go = 1'b1;
          q_nxt.wd_cnt = 14'h0000;
          if (q_r.option[`WDSR_OPT_PRE_ASSIGN]) begin
            q_nxt.presc = 7'h00;
          end
        end
        if (rstpin_low || wd_expire) begin
          q_nxt.mode = wdsr_pkg::ST_HOLD;
          q_nxt.devrst = `WDSR_DEVRST_CYC;
          q_nxt.core_rst = 1'b1;
        end
      end
      // Wake from sleep always passes through a device reset.
      wdsr_pkg::ST_SLEEP: begin
        if (rstpin_low) begin
          q_nxt.flags = `WDSR_CAUSE_RSTPIN_SLEEP;
        end else if (wd_expire) begin
          q_nxt.flags = `WDSR_CAUSE_WD_SLEEP;
        end else if (pin_diff && !q_r.option[`WDSR_OPT_PIN_WAKE_N]) begin
          q_nxt.flags = `WDSR_CAUSE_PIN_WAKE;
        end else if (cmp_diff && q_r.cmp_en) begin
          q_nxt.flags = `WDSR_CAUSE_CMP_WAKE;
        end
        if (rstpin_low || wd_expire || (pin_diff && !q_r.option[`WDSR_OPT_PIN_WAKE_N]) ||
            (cmp_diff && q_r.cmp_en)) begin
          q_nxt.mode = wdsr_pkg::ST_HOLD;
          q_nxt.devrst = `WDSR_DEVRST_CYC;
          q_nxt.core_rst = 1'b1;
          q_nxt.clk_en = 1'b1;
          q_nxt.io_hold = 1'b0;
          q_nxt.wd_cnt = 14'h0000;
        end
      end
      // Serial programming; pin 1 rising edges clock, pin 0 carries data LSB first.
      wdsr_pkg::ST_PROG: begin
        q_nxt.core_rst = 1'b1;
        if (!q_r.stab[`WDSR_SY_HV]) begin
          q_nxt.mode = wdsr_pkg::ST_HOLD;
          q_nxt.devrst = `WDSR_DEVRST_CYC;
          q_nxt.pin0_oe_n = 1'b1;
          q_nxt.flags[`WDSR_F_CMP] = 1'b0;
          q_nxt.flags[`WDSR_F_PIN] = 1'b0;
        end else if (pg_clk_rise) begin
          q_nxt.pg_cnt = q_r.pg_cnt + 5'h01;
          q_nxt.pg_shift = {q_r.stab[`WDSR_SY_PIN0], q_r.pg_shift[15:1]};
          case (q_r.pg)
            wdsr_pkg::PG_CMD: begin
              if (q_r.pg_cnt == `WDSR_CMD_LAST) begin
                cmd_v = {q_r.stab[`WDSR_SY_PIN0], q_r.pg_shift[15:11]};
                q_nxt.pg_cnt = 5'h00;
                if (cmd_v == `WDSR_CMD_LOAD) begin
                  q_nxt.pg = wdsr_pkg::PG_DIN;
                end else if (cmd_v == `WDSR_CMD_READ) begin
                  if (is_id(q_r.pg_addr)) begin
                    word_v = {`WDSR_PAD_ZERO, q_r.id_mem[q_r.pg_addr[1:0]]};
                  end else if (read_allowed(q_r.pg_addr, I_CFG_CP_N)) begin
                    word_v = {`WDSR_PAD_ZERO, I_PMEM_RDATA};
                  end
                  q_nxt.pg = wdsr_pkg::PG_DOUT;
                  q_nxt.pg_shift = word_v;
                  q_nxt.pin0_out = word_v[0];
                  q_nxt.pin0_oe_n = 1'b0;
                end else if (cmd_v == `WDSR_CMD_INC) begin
                  q_nxt.pg_addr = q_r.pg_addr + 10'h001;
                end
              end
            end
            wdsr_pkg::PG_DIN: begin
              if (q_r.pg_cnt == `WDSR_DATA_LAST) begin
                word_v = {q_r.stab[`WDSR_SY_PIN0], q_r.pg_shift[15:1]};
                if (is_id(q_r.pg_addr)) begin
                  q_nxt.id_mem[q_r.pg_addr[1:0]] = word_v[11:0];
                end
                q_nxt.pg = wdsr_pkg::PG_CMD;
                q_nxt.pg_cnt = 5'h00;
              end
            end
            wdsr_pkg::PG_DOUT: begin
              q_nxt.pg_shift = {1'b0, q_r.pg_shift[15:1]};
              q_nxt.pin0_out = q_r.pg_shift[1];
              if (q_r.pg_cnt == `WDSR_DATA_LAST) begin
                q_nxt.pg = wdsr_pkg::PG_CMD;
                q_nxt.pg_cnt = 5'h00;
                q_nxt.pin0_oe_n = 1'b1;
                q_nxt.pin0_out = 1'b0;
              end
            end
            default: begin
              q_nxt.pg = wdsr_pkg::PG_CMD;
            end
          endcase
        end
      end
      default: begin
        q_nxt.mode = wdsr_pkg::ST_HOLD;
      end
    endcase

    // Programming entry wins over every other event; pins 0 and 1 must be low.
    if (q_r.mode != wdsr_pkg::ST_PROG && hv_rise && !q_r.stab[`WDSR_SY_PIN0] &&
        !q_r.stab[`WDSR_SY_PIN1]) begin
      q_nxt.mode = wdsr_pkg::ST_PROG;
      q_nxt.core_rst = 1'b1;
      q_nxt.clk_en = 1'b1;
      q_nxt.io_hold = 1'b0;
      q_nxt.pg = wdsr_pkg::PG_CMD;
      q_nxt.pg_cnt = 5'h00;
      q_nxt.pg_addr = 10'h000;
    end
    q_nxt.pmem_ok = read_allowed(q_r.pg_addr, I_CFG_CP_N);
    q_nxt.prog = (q_nxt.mode == wdsr_pkg::ST_PROG);
  end

  // State register; power-on reset loads constants only.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      q_r <= '0;
      q_r.mode <= wdsr_pkg::ST_HOLD;
      q_r.devrst <= P_DEVRST_POR_CYC;
      q_r.option <= `WDSR_OPTION_RST;
      q_r.flags <= `WDSR_CAUSE_POWERUP;
      q_r.core_rst <= 1'b1;
      q_r.clk_en <= 1'b1;
      q_r.rstpin_oe_n <= 1'b1;
      q_r.pin0_oe_n <= 1'b1;
      q_r.pmem_ok <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign O_RDATA = q_r.rdata;
  assign O_CORE_RST = q_r.core_rst;
  assign O_CORE_CLK_EN = q_r.clk_en;
  assign O_IO_HOLD = q_r.io_hold;
  assign O_RSTPIN_OE_N = q_r.rstpin_oe_n;
  assign O_PIN0_OUT = q_r.pin0_out;
  assign O_PIN0_OE_N = q_r.pin0_oe_n;
  assign O_PROG_MODE = q_r.prog;
  assign O_PMEM_ADDR = q_r.pg_addr;
  assign O_PMEM_RD_OK = q_r.pmem_ok;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence seq_sleep_taken;
    sleep_go && !hv_rise;
  endsequence
  sequence seq_asleep_state;
    q_r.mode == wdsr_pkg::ST_SLEEP && q_r.flags[`WDSR_F_TIMEOUT] &&
    !q_r.flags[`WDSR_F_PDOWN] && !q_r.clk_en && q_r.io_hold && q_r.wd_cnt == 14'h0000;
  endsequence

  a_sleep_entry: assert property (seq_sleep_taken |=> seq_asleep_state)
    else $error("Sleep entry did not set flags, stop oscillator and clear watchdog.");
  a_wd_awake_cause: assert property (q_r.mode == wdsr_pkg::ST_RUN && wd_expire && !rstpin_low
      && !hv_rise |=> !q_r.flags[`WDSR_F_TIMEOUT] && q_r.core_rst && q_r.flags[`WDSR_F_PDOWN]
      == $past(q_r.flags[`WDSR_F_PDOWN]))
    else $error("Watchdog timeout while awake gave wrong flags or no reset.");
  a_wd_sleep_wake: assert property (q_r.mode == wdsr_pkg::ST_SLEEP && wd_expire && !rstpin_low
      && !hv_rise |=> q_r.flags == `WDSR_CAUSE_WD_SLEEP && q_r.mode == wdsr_pkg::ST_HOLD)
    else $error("Watchdog wake from sleep gave wrong cause.");
  a_kick_clears: assert property (kick_go && !hv_rise |=> q_r.wd_cnt == 14'h0000)
    else $error("Kick did not clear the watchdog counter.");
  a_fuse_off: assert property (!I_CFG_WD_FUSE |-> !wd_expire)
    else $error("Watchdog expired with the fuse cleared.");
  a_pin_never: assert property (O_RSTPIN_OE_N)
    else $error("Reset pin driven by the device.");
  a_io_frozen: assert property (q_r.mode == wdsr_pkg::ST_SLEEP |-> O_IO_HOLD)
    else $error("Port drivers released during sleep.");
  a_pin_wake_cause: assert property (q_r.mode == wdsr_pkg::ST_SLEEP && pin_diff &&
      !q_r.option[`WDSR_OPT_PIN_WAKE_N] && !rstpin_low && !wd_expire && !hv_rise
      |=> q_r.flags == `WDSR_CAUSE_PIN_WAKE && q_r.wd_cnt == 14'h0000)
    else $error("Pin change wake gave wrong cause.");
  a_hold_reset: assert property (q_r.mode == wdsr_pkg::ST_HOLD && q_r.devrst ==
      `WDSR_DEVRST_CYC |-> O_CORE_RST [*8])
    else $error("Core released before the reset timer ran out.");
  a_readout_gate: assert property (O_PMEM_RD_OK == read_allowed($past(q_r.pg_addr),
      $past(I_CFG_CP_N)))
    else $error("Readout permission does not match protection.");
endmodule : wdsr_top

//--- wdsr_regs.svh
/*
 * Register offsets, field positions, reset values, cause codes, timing
 * figures and programming command codes of the watchdog, sleep and
 * reset-cause block.
 * Assumes it is included by the package and by the top module only.
 */
`ifndef WDSR_REGS_SVH
`define WDSR_REGS_SVH

// ****************************************************************
// Register map and fields
// ****************************************************************
`define WDSR_ADDR_OPTION 2'h0
`define WDSR_ADDR_STATUS 2'h1
`define WDSR_ADDR_WAKECTL 2'h2
`define WDSR_OPTION_RST 8'hff
`define WDSR_OPT_PIN_WAKE_N 7
`define WDSR_OPT_PRE_ASSIGN 3
`define WDSR_OPT_RATIO_HI 2
`define WDSR_OPT_RATIO_LO 0
`define WDSR_STAT_PIN_WAKE 7
`define WDSR_STAT_CMP_WAKE 6
`define WDSR_STAT_TIMEOUT 4
`define WDSR_STAT_PDOWN 3
`define WDSR_WAKECTL_CMP_EN 0

// ****************************************************************
// Reset-cause codes {comparator, pin, timeout, powerdown}
// ****************************************************************
`define WDSR_F_CMP 3
`define WDSR_F_PIN 2
`define WDSR_F_TIMEOUT 1
`define WDSR_F_PDOWN 0
`define WDSR_CAUSE_POWERUP 4'h3
`define WDSR_CAUSE_WD_SLEEP 4'h0
`define WDSR_CAUSE_RSTPIN_SLEEP 4'h2
`define WDSR_CAUSE_PIN_WAKE 4'h6
`define WDSR_CAUSE_CMP_WAKE 4'ha

// ****************************************************************
// Synchroniser bit positions
// ****************************************************************
`define WDSR_SY_OSC 0
`define WDSR_SY_CMP 1
`define WDSR_SY_PIN0 2
`define WDSR_SY_PIN1 3
`define WDSR_SY_PIN3 4
`define WDSR_SY_HV 5
`define WDSR_SY_W 6

// ****************************************************************
// Timing, in ns as printed, and derived counts
// ****************************************************************
`define WDSR_CLK_NS 100
`define WDSR_WDOSC_NS 2000
`define WDSR_WD_PERIOD_NS 18000000
`define WDSR_DEVRST_POR_NS 18000000
`define WDSR_DEVRST_NS 10000
`define WDSR_DEVRST_CYC 18'((`WDSR_DEVRST_NS + `WDSR_CLK_NS - 1) / `WDSR_CLK_NS)
`define WDSR_DEVRST_POR_CYC ((`WDSR_DEVRST_POR_NS + `WDSR_CLK_NS - 1) / `WDSR_CLK_NS)
`define WDSR_WD_TICKS (`WDSR_WD_PERIOD_NS / `WDSR_WDOSC_NS)

// ****************************************************************
// Serial programming
// ****************************************************************
`define WDSR_CMD_LOAD 6'h02
`define WDSR_CMD_READ 6'h04
`define WDSR_CMD_INC 6'h06
`define WDSR_CMD_LAST 5'h05
`define WDSR_DATA_LAST 5'h0f
`define WDSR_ID_BASE 10'h200
`define WDSR_OPEN_LIMIT 10'h040
`define WDSR_LAST_ADDR 10'h1ff
`define WDSR_PAD_ZERO 4'h0

`endif

//--- wdsr_pkg.sv
/*
 * Types of the watchdog, sleep and reset-cause block: state enums and
 * the packed struct that holds all state of the top module.
 * Assumes wdsr_regs.svh is on the include path.
 */
`include "wdsr_regs.svh"

package wdsr_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_PROG} wdsr_mode_t;
  typedef enum logic [1:0] {PG_CMD, PG_DIN, PG_DOUT} wdsr_pgm_t;

  typedef struct packed {
    logic [`WDSR_SY_W-1:0] s1;
    logic [`WDSR_SY_W-1:0] s2;
    logic [`WDSR_SY_W-1:0] s3;
    logic [`WDSR_SY_W-1:0] stab;
    wdsr_mode_t mode;
    logic [17:0] devrst;
    logic [7:0] option;
    logic cmp_en;
    logic [3:0] flags;
    logic [2:0] port_latch;
    logic cmp_latch;
    logic [6:0] presc;
    logic [13:0] wd_cnt;
    logic [7:0] rdata;
    logic core_rst;
    logic clk_en;
    logic io_hold;
    logic rstpin_oe_n;
    wdsr_pgm_t pg;
    logic [4:0] pg_cnt;
    logic [15:0] pg_shift;
    logic [9:0] pg_addr;
    logic [3:0][11:0] id_mem;
    logic pin0_out;
    logic pin0_oe_n;
    logic pmem_ok;
    logic prog;
  } wdsr_state_t;

endpackage : wdsr_pkg

//--- wdsr_pin_model.sv
/* Pin-side partner: reset source and serial programmer.
   Assumes its tasks are called from the bench on the clock i_clk. */
module wdsr_pin_model (
  input wire logic i_clk, // Pacing clock.
  input wire logic i_d_out, // Device data out.
  input wire logic i_d_oe_n, // Device data enable, low drives.
  output logic o_pin0, // Data pin level.
  output logic o_pin1, // Clock pin level.
  output logic o_pin3, // Reset pin, pulled up.
  output logic o_hv // Pin 3 at the programming level.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic d_r;
  logic [15:0] rx; // Word read back from the data pin, LSB first.
  // ********
  // Pins
  // ********
  // The device owns the data pin while it drives, so no stale value shows.
  assign o_pin0 = i_d_oe_n ? d_r : i_d_out;
  // Idle levels: reset pin at its pull-up, clock and data low.
  initial begin
    d_r = 1'b0;
    o_pin1 = 1'b0;
    o_pin3 = 1'b1;
    o_hv = 1'b0;
  end
  task automatic set_d(input logic v);
    @(posedge i_clk);
    d_r <= v;
  endtask : set_d
  // A short low pulse; the device must not keep it.
  task automatic pulse_rst();
    @(posedge i_clk);
    o_pin3 <= 1'b0;
    repeat (10) @(posedge i_clk);
    o_pin3 <= 1'b1;
  endtask : pulse_rst
  // Clock and data are held low while the high level rises.
  task automatic enter(input logic v);
    @(posedge i_clk);
    d_r <= 1'b0;
    o_pin1 <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_hv <= v;
    repeat (8) @(posedge i_clk);
  endtask : enter
  // LSB first; each half clock lasts 5 cycles, above the minimum.
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      d_r <= v[i];
      repeat (5) @(posedge i_clk);
      rx = {o_pin0, rx[15:1]};
      o_pin1 <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_pin1 <= 1'b0;
    end
  endtask : shift
endmodule : wdsr_pin_model

//--- tb.sv
/* Self-checking bench of the watchdog, sleep and reset-cause block.
   Assumes shortened counts: 20 cycles power-on timer, 8 watchdog ticks. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, we, re, fuse, osc, cmp, p0, p1, p3, hv;
  logic core_rst, clk_en, io_hold, oe_n, d_out, d_oe_n, prog, rd_ok, cp_n;
  logic [9:0] pmem_addr;
  logic [11:0] pmem;
  logic [1:0] addr;
  logic [2:0] ins;
  logic [7:0] wdata, rdata;
  int n_errors, n_compared;
  wdsr_top #(.P_DEVRST_POR_CYC(18'd20), .P_WD_TICKS(14'd8)) u_wdsr_top (.I_CLK_SYS(clk),
    .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WE(we), .I_RE(re), .O_RDATA(rdata),
    .I_KICK(ins[0]), .I_SLEEP(ins[1]), .I_PORT_ACCESS(ins[2]), .I_CFG_WD_FUSE(fuse),
    .I_CFG_RSTPIN_EN(1'b1), .I_CFG_CP_N(cp_n), .I_WDT_OSC(osc), .I_CMP_OUT(cmp),
    .I_PORT_PIN0(p0), .I_PORT_PIN1(p1), .I_PORT_PIN3(p3), .I_PIN3_HV(hv),
    .I_PMEM_RDATA(pmem), .O_CORE_RST(core_rst), .O_CORE_CLK_EN(clk_en),
    .O_IO_HOLD(io_hold), .O_RSTPIN_OE_N(oe_n), .O_PIN0_OUT(d_out), .O_PIN0_OE_N(d_oe_n),
    .O_PROG_MODE(prog), .O_PMEM_ADDR(pmem_addr), .O_PMEM_RD_OK(rd_ok));
  wdsr_pin_model u_wdsr_pin_model (.i_clk(clk), .i_d_out(d_out), .i_d_oe_n(d_oe_n),
    .o_pin0(p0), .o_pin1(p1), .o_pin3(p3), .o_hv(hv));
  // ********
  // Clocks
  // ********
  // System clock at 10 MHz, watchdog oscillator at 2 us, unrelated.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #333 forever #1000 osc = ~osc;
  end
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk("read", rdata, e);
  endtask : rd
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    ins <= v;
    @(posedge clk);
    ins <= 3'h0;
  endtask : pulse
  // Bounded wait for the core reset to reach a level.
  task automatic wait_rst(input logic v, input int n);
    for (int i = 0; i < n && core_rst !== v; i++) @(posedge clk) #1;
    chk("core reset", core_rst, v);
  endtask : wait_rst
  // ********
  // Scenarios
  // ********
  task automatic t_por();
    rd(2'h1, 8'h18);
    rd(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h18);
    rd(2'h3, 8'h00);
    wait_rst(1'b0, 300);
  endtask : t_por
  // Prescaler 1:2 doubles the 160-cycle span.
  task automatic t_wd_awake();
    wr(2'h0, 8'h89);
    pulse(3'h1);
    repeat (250) @(posedge clk);
    chk("early reset", core_rst, 1'b0);
    wait_rst(1'b1, 200);
    chk("reset pin enable", oe_n, 1'b1);
    wait_rst(1'b0, 300);
    rd(2'h1, 8'h08);
  endtask : t_wd_awake
  task automatic t_kick();
    wr(2'h0, 8'h81);
    repeat (5) begin
      repeat (100) @(posedge clk);
      pulse(3'h1);
    end
    chk("kicked reset", core_rst, 1'b0);
  endtask : t_kick
  task automatic t_sleep_wd();
    wr(2'h0, 8'h81);
    pulse(3'h2);
    #1 chk("clock enable", clk_en, 1'b0);
    chk("io hold", io_hold, 1'b1);
    repeat (100) @(posedge clk);
    chk("sleep reset", core_rst, 1'b0);
    wait_rst(1'b1, 200);
    wait_rst(1'b0, 300);
    rd(2'h1, 8'h00);
    chk("clock enable", clk_en, 1'b1);
  endtask : t_sleep_wd
  // Kinds: 0 pin change, 1 comparator, 2 reset pin, 3 stale latch.
  task automatic t_wake(input int k, input logic [7:0] e);
    wr(2'h0, 8'h01);
    wr(2'h2, 8'h01);
    if (k != 3) pulse(3'h4);
    pulse(3'h2);
    if (k != 3) begin
      repeat (300) @(posedge clk);
      chk("asleep", core_rst, 1'b0);
    end
    if (k == 0) u_wdsr_pin_model.set_d(1'b1);
    if (k == 1) cmp <= ~cmp;
    if (k == 2) u_wdsr_pin_model.pulse_rst();
    wait_rst(1'b1, 60);
    wait_rst(1'b0, 300);
    rd(2'h1, e);
  endtask : t_wake
  task automatic t_prog();
    u_wdsr_pin_model.enter(1'b1);
    cp_n <= 1'b0;
    chk("prog mode", prog, 1'b1);
    chk("pmem address", pmem_addr[7:0], 8'h00);
    u_wdsr_pin_model.shift(16'h0004, 6);
    repeat (6) @(posedge clk);
    chk("data enable", d_oe_n, 1'b0);
    chk("readout ok", rd_ok, 1'b1);
    u_wdsr_pin_model.shift(16'h0000, 16);
    repeat (6) @(posedge clk);
    chk("data enable", d_oe_n, 1'b1);
    chk("read word low", u_wdsr_pin_model.rx[7:0], 8'ha3);
    chk("read word high", u_wdsr_pin_model.rx[15:8], 8'h05);
    u_wdsr_pin_model.enter(1'b0);
    wait_rst(1'b0, 300);
    chk("prog mode", prog, 1'b0);
  endtask : t_prog
  // Main sequence, with every input given a value at time zero.
  initial begin
    {rst, we, re, ins, addr, wdata, cmp} = '1;
    {we, re, ins, cmp} = '0;
    {fuse, cp_n, pmem} = {2'h3, 12'h5a3};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_wd_awake();
    t_kick();
    t_sleep_wd();
    fuse <= 1'b0;
    t_wake(0, 8'h90);
    t_wake(3, 8'h90);
    t_wake(1, 8'h50);
    t_wake(2, 8'h10);
    t_prog();
    report_and_stop();
  end
  // Hang guard, well beyond the expected run.
  initial begin
    #3000000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb
